// [shared/acm_defs.svh]
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH

// Register addresses on the special function register bus.
`define ACM_CNT_LO_ADDR   8'hf9
`define ACM_CNT_HI_ADDR   8'hfa
`define ACM_MODE0_ADDR    8'hda
`define ACM_MODE1_ADDR    8'hdb
`define ACM_MODE2_ADDR    8'hdc
`define ACM_CMP0_LO_ADDR  8'hfb
`define ACM_CMP0_HI_ADDR  8'hfc
`define ACM_CMP1_LO_ADDR  8'he9
`define ACM_CMP1_HI_ADDR  8'hea
`define ACM_CMP2_LO_ADDR  8'heb
`define ACM_CMP2_HI_ADDR  8'hec

// Field positions of the module mode control register.
`define ACM_WIDE_BIT      7
`define ACM_ECOM_BIT      6
`define ACM_RISE_BIT      5
`define ACM_FALL_BIT      4
`define ACM_MATCH_BIT     3
`define ACM_TOGGLE_BIT    2
`define ACM_PWM_BIT       1
`define ACM_IRQEN_BIT     0

// Reset values.
`define ACM_MODE_RESET    8'h00
`define ACM_BYTE_RESET    8'h00
`define ACM_WORD_RESET    16'h0000

// The module that the watchdog takes over.
`define ACM_WDOG_CHAN     2

`endif

// [shared/acm_pkg.sv]
package acm_pkg;

  typedef logic [7:0]  acm_byte_t;
  typedef logic [15:0] acm_word_t;

  // Function of one module as decoded from its mode bits.
  typedef enum logic [1:0] {
    ACM_FN_IDLE   = 2'b00,
    ACM_FN_TOGGLE = 2'b01,
    ACM_FN_PWM    = 2'b10,
    ACM_FN_FREQ   = 2'b11
  } acm_func_t;

  // Cycle length of the narrow pulse width mode.
  typedef enum logic [1:0] {
    ACM_LEN_8  = 2'b00,
    ACM_LEN_9  = 2'b01,
    ACM_LEN_10 = 2'b10,
    ACM_LEN_11 = 2'b11
  } acm_len_t;

endpackage : acm_pkg

// [logic/acm_channel.sv]
`include "acm_defs.svh"

module acm_channel (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Shared counter and this module's setup.
  input  wire acm_pkg::acm_word_t counter_value,
  input  wire acm_pkg::acm_word_t compare_value,
  input  wire acm_pkg::acm_byte_t mode,
  input  wire acm_pkg::acm_len_t  cycle_length_select,
  // Results.
  output logic                  match_hit,
  output logic                  module_output_pin
);
  import acm_pkg::*;

  acm_func_t func;
  acm_word_t len_mask;
  logic      ecom;
  logic      low_match;
  logic      pwm_level;

  assign ecom = mode[`ACM_ECOM_BIT];

  always_comb begin
    unique case ({mode[`ACM_PWM_BIT], mode[`ACM_TOGGLE_BIT]})
      2'b11:   func = ACM_FN_FREQ;
      2'b10:   func = ACM_FN_PWM;
      2'b01:   func = ACM_FN_TOGGLE;
      default: func = ACM_FN_IDLE;
    endcase
  end

  always_comb begin
    if (mode[`ACM_WIDE_BIT]) begin
      len_mask = 16'hffff;
    end else begin
      unique case (cycle_length_select)
        ACM_LEN_8:  len_mask = 16'h00ff;
        ACM_LEN_9:  len_mask = 16'h01ff;
        ACM_LEN_10: len_mask = 16'h03ff;
        default:    len_mask = 16'h07ff;
      endcase
    end
  end

  assign match_hit = ecom && (counter_value == compare_value);
  assign low_match = ecom && (counter_value[7:0] == compare_value[7:0]);
  // The pin rises once the counter reaches the compare value within the cycle.
  assign pwm_level = (counter_value & len_mask) >= (compare_value & len_mask);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      module_output_pin <= 1'b0;
    end else begin
      unique case (func)
        ACM_FN_TOGGLE: if (match_hit) module_output_pin <= ~module_output_pin;
        ACM_FN_FREQ:   if (low_match) module_output_pin <= ~module_output_pin;
        ACM_FN_PWM:    if (ecom) module_output_pin <= pwm_level;
        default:       module_output_pin <= module_output_pin;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_toggle_on_match;
    func == ACM_FN_TOGGLE && match_hit |=> module_output_pin != $past(module_output_pin);
  endproperty
  a_toggle_on_match: assert property (p_toggle_on_match)
    else $error("toggle mode did not invert the pin on a match");

  property p_freq_quiet;
    func == ACM_FN_FREQ && !low_match |=> $stable(module_output_pin);
  endproperty
  a_freq_quiet: assert property (p_freq_quiet)
    else $error("frequency mode pin moved without a low byte match");

  property p_pwm_level;
    func == ACM_FN_PWM && ecom |=> module_output_pin == $past(pwm_level);
  endproperty
  a_pwm_level: assert property (p_pwm_level)
    else $error("pwm pin does not follow the compare result");

  property p_narrow_mask;
    !mode[`ACM_WIDE_BIT] && cycle_length_select == ACM_LEN_8 |-> len_mask == 16'h00ff;
  endproperty
  a_narrow_mask: assert property (p_narrow_mask)
    else $error("eight bit cycle length not applied");

  property p_ecom_gates;
    !ecom |-> !match_hit ##1 (func != ACM_FN_TOGGLE || $stable(module_output_pin));
  endproperty
  a_ecom_gates: assert property (p_ecom_gates)
    else $error("comparator disabled but module still matched");

  c_pwm_rise: cover property (func == ACM_FN_PWM ##1 $rose(module_output_pin));

endmodule : acm_channel

// [logic/acm_top.sv]
// Notes on behaviour
// - With match enabled, a counter equal to the module's compare value sets its flag.
// - With toggle enabled, each match inverts the module's output pin.
// - Toggle and pulse width together select frequency output mode.
// - Pulse width alone drives a pulse width modulated waveform on the pin.
// - The wide select bit picks 16-bit pulse width, else the shared 8 to 11-bit length.
// - A flag raises its interrupt request only while its interrupt enable is 1.
// - While the watchdog is enabled, writes to module 2's mode register are ignored.
// - While the watchdog is enabled, writes to the counter low byte are blocked.
// - While the watchdog is enabled, writes to the counter high byte are blocked.
// - The high byte reads a snapshot that is taken only when the low byte is read.
// - A 16-bit counter is readable and writable as low byte 0xf9 and high byte, reset to 0.
// - Cycle length codes 00, 01, 10, 11 give 8, 9, 10 and 11 bits.
// - Mode bits 5 and 4 enable capture on rising and falling edges of the input.
// - Mode bit 6 enables the comparator and gates match, toggle and pulse width.
`include "acm_defs.svh"

module acm_top (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Special function register bus.
  input  wire acm_pkg::acm_byte_t   sfr_addr,
  input  wire acm_pkg::acm_byte_t   sfr_wdata,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  output acm_pkg::acm_byte_t        sfr_rdata,
  // Array level control from neighbouring logic.
  input  wire logic                 watchdog_enable,
  input  wire acm_pkg::acm_len_t    cycle_length_select,
  input  wire logic                 count_run,
  input  wire logic [2:0]           flag_clear,
  // Capture inputs from pins.
  input  wire logic [2:0]           capture_pin,
  // Module results.
  output logic [2:0]                capcomp_flag,
  output logic [2:0]                flag_irq,
  output logic [2:0]                module_output_pin
);
  import acm_pkg::*;

  localparam acm_byte_t MODE_ADDR [3] = '{`ACM_MODE0_ADDR, `ACM_MODE1_ADDR, `ACM_MODE2_ADDR};
  localparam acm_byte_t CMPL_ADDR [3] = '{`ACM_CMP0_LO_ADDR, `ACM_CMP1_LO_ADDR,
                                          `ACM_CMP2_LO_ADDR};
  localparam acm_byte_t CMPH_ADDR [3] = '{`ACM_CMP0_HI_ADDR, `ACM_CMP1_HI_ADDR,
                                          `ACM_CMP2_HI_ADDR};

  acm_word_t counter_q;
  acm_byte_t snap_q;
  acm_byte_t mode_q   [3];
  acm_word_t cmp_q    [3];
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic [2:0] match_hit;
  logic [2:0] cap_hit;
  logic       wr_cnt_lo;
  logic       wr_cnt_hi;
  logic       rd_cnt_lo;

  // Counter writes are dropped while the watchdog owns the counter.
  assign wr_cnt_lo = sfr_wr && sfr_addr == `ACM_CNT_LO_ADDR && !watchdog_enable;
  assign wr_cnt_hi = sfr_wr && sfr_addr == `ACM_CNT_HI_ADDR && !watchdog_enable;
  assign rd_cnt_lo = sfr_rd && sfr_addr == `ACM_CNT_LO_ADDR;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_q <= `ACM_WORD_RESET;
    end else if (wr_cnt_lo) begin
      counter_q[7:0] <= sfr_wdata;
    end else if (wr_cnt_hi) begin
      counter_q[15:8] <= sfr_wdata;
    end else if (count_run) begin
      counter_q <= counter_q + 16'h0001;
    end
  end

  // The snapshot keeps a 16-bit read coherent across two byte reads.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_q <= `ACM_BYTE_RESET;
    end else if (rd_cnt_lo) begin
      snap_q <= counter_q[15:8];
    end
  end

  // Pins are asynchronous to clk, so they pass two flip-flops first.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      prev_q  <= 3'h0;
    end else begin
      sync1_q <= capture_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_chan
      logic mode_wr;
      logic cmpl_wr;
      logic cmph_wr;
      logic locked;

      // Module 2 belongs to the watchdog while it is enabled.
      assign locked  = (ch == `ACM_WDOG_CHAN) && watchdog_enable;
      assign mode_wr = sfr_wr && sfr_addr == MODE_ADDR[ch] && !locked;
      assign cmpl_wr = sfr_wr && sfr_addr == CMPL_ADDR[ch];
      assign cmph_wr = sfr_wr && sfr_addr == CMPH_ADDR[ch];
      assign cap_hit[ch] =
          (mode_q[ch][`ACM_RISE_BIT] && sync2_q[ch] && !prev_q[ch]) ||
          (mode_q[ch][`ACM_FALL_BIT] && !sync2_q[ch] && prev_q[ch]);

      // Writing the compare low byte stops the comparator until the high byte lands, except on module 2 while the watchdog is enabled.
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mode_q[ch] <= `ACM_MODE_RESET;
        end else if (mode_wr) begin
          mode_q[ch] <= sfr_wdata;
        end else if (cmpl_wr && !locked) begin
          mode_q[ch][`ACM_ECOM_BIT] <= 1'b0;
        end else if (cmph_wr && !locked) begin
          mode_q[ch][`ACM_ECOM_BIT] <= 1'b1;
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          cmp_q[ch] <= `ACM_WORD_RESET;
        end else if (cap_hit[ch]) begin
          cmp_q[ch] <= counter_q;
        end else if (cmpl_wr) begin
          cmp_q[ch][7:0] <= sfr_wdata;
        end else if (cmph_wr) begin
          cmp_q[ch][15:8] <= sfr_wdata;
        end
      end

      // A new event wins over a clear in the same cycle.
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          capcomp_flag[ch] <= 1'b0;
        end else if ((match_hit[ch] && mode_q[ch][`ACM_MATCH_BIT]) || cap_hit[ch]) begin
          capcomp_flag[ch] <= 1'b1;
        end else if (flag_clear[ch]) begin
          capcomp_flag[ch] <= 1'b0;
        end
      end

      assign flag_irq[ch] = capcomp_flag[ch] && mode_q[ch][`ACM_IRQEN_BIT];

      acm_channel u_chan (
        .clk                 (clk),
        .reset_n             (reset_n),
        .counter_value       (counter_q),
        .compare_value       (cmp_q[ch]),
        .mode                (mode_q[ch]),
        .cycle_length_select (cycle_length_select),
        .match_hit           (match_hit[ch]),
        .module_output_pin   (module_output_pin[ch])
      );
    end
  endgenerate

  // Read data is registered and appears the cycle after the read strobe.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= `ACM_BYTE_RESET;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        `ACM_CNT_LO_ADDR:  sfr_rdata <= counter_q[7:0];
        `ACM_CNT_HI_ADDR:  sfr_rdata <= snap_q;
        `ACM_MODE0_ADDR:   sfr_rdata <= mode_q[0];
        `ACM_MODE1_ADDR:   sfr_rdata <= mode_q[1];
        `ACM_MODE2_ADDR:   sfr_rdata <= mode_q[2];
        `ACM_CMP0_LO_ADDR: sfr_rdata <= cmp_q[0][7:0];
        `ACM_CMP0_HI_ADDR: sfr_rdata <= cmp_q[0][15:8];
        `ACM_CMP1_LO_ADDR: sfr_rdata <= cmp_q[1][7:0];
        `ACM_CMP1_HI_ADDR: sfr_rdata <= cmp_q[1][15:8];
        `ACM_CMP2_LO_ADDR: sfr_rdata <= cmp_q[2][7:0];
        `ACM_CMP2_HI_ADDR: sfr_rdata <= cmp_q[2][15:8];
        default:           sfr_rdata <= `ACM_BYTE_RESET;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_match_sets_flag;
    match_hit[0] && mode_q[0][`ACM_MATCH_BIT] && counter_q == cmp_q[0] |=> capcomp_flag[0];
  endproperty
  a_match_sets_flag: assert property (p_match_sets_flag)
    else $error("match did not set the module flag");

  property p_irq_masked;
    flag_irq[0] |-> capcomp_flag[0] && mode_q[0][`ACM_IRQEN_BIT];
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt request raised while masked");

  property p_wdog_mode_lock;
    watchdog_enable && sfr_wr && sfr_addr == `ACM_MODE2_ADDR |=> $stable(mode_q[2]);
  endproperty
  a_wdog_mode_lock: assert property (p_wdog_mode_lock)
    else $error("module 2 mode changed under watchdog");

  property p_wdog_lo_lock;
    watchdog_enable && sfr_wr && sfr_addr == `ACM_CNT_LO_ADDR
      |=> counter_q == $past(counter_q) + {15'h0000, $past(count_run)};
  endproperty
  a_wdog_lo_lock: assert property (p_wdog_lo_lock)
    else $error("counter low byte written under watchdog");

  property p_wdog_hi_lock;
    watchdog_enable && sfr_wr && sfr_addr == `ACM_CNT_HI_ADDR
      |=> counter_q == $past(counter_q) + {15'h0000, $past(count_run)};
  endproperty
  a_wdog_hi_lock: assert property (p_wdog_hi_lock)
    else $error("counter high byte written under watchdog");

  property p_snap_only_on_low_read;
    !rd_cnt_lo |=> $stable(snap_q);
  endproperty
  a_snap_only_on_low_read: assert property (p_snap_only_on_low_read)
    else $error("snapshot changed without a low byte read");

  property p_high_read_snap;
    rd_cnt_lo ##1 (sfr_rd && sfr_addr == `ACM_CNT_HI_ADDR)
      |=> sfr_rdata == $past(counter_q[15:8], 2);
  endproperty
  a_high_read_snap: assert property (p_high_read_snap)
    else $error("high byte read did not return the snapshot");

  property p_low_write;
    wr_cnt_lo |=> counter_q[7:0] == $past(sfr_wdata);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("counter low byte write lost");

  property p_capture;
    cap_hit[2] |=> capcomp_flag[2] && cmp_q[2] == $past(counter_q);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture edge did not load compare and flag");

  c_match_flag: cover property (match_hit[0] && mode_q[0][`ACM_MATCH_BIT] ##1 capcomp_flag[0]);
  c_wdog_block: cover property (watchdog_enable && sfr_wr && sfr_addr == `ACM_CNT_LO_ADDR);
  c_snapshot:   cover property (rd_cnt_lo ##1 sfr_rd && sfr_addr == `ACM_CNT_HI_ADDR);
  c_capture:    cover property (cap_hit[2]);

endmodule : acm_top

// [tb/tb_top.sv]
`include "acm_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acm_pkg::*;

  logic      clk;
  logic      reset_n;
  acm_byte_t sfr_addr;
  acm_byte_t sfr_wdata;
  logic      sfr_wr;
  logic      sfr_rd;
  acm_byte_t sfr_rdata;
  logic      watchdog_enable;
  acm_len_t  cycle_length_select;
  logic      count_run;
  logic [2:0] flag_clear;
  logic [2:0] capture_pin;
  logic [2:0] capcomp_flag;
  logic [2:0] flag_irq;
  logic [2:0] module_output_pin;
  int        err_count;
  int        samples_checked;
  acm_word_t cnt;
  acm_word_t mask;
  acm_byte_t cmp_lo_addr [3] = '{`ACM_CMP0_LO_ADDR, `ACM_CMP1_LO_ADDR, `ACM_CMP2_LO_ADDR};
  acm_byte_t cmp_hi_addr [3] = '{`ACM_CMP0_HI_ADDR, `ACM_CMP1_HI_ADDR, `ACM_CMP2_HI_ADDR};

  acm_top dut (
    .clk                 (clk),
    .reset_n             (reset_n),
    .sfr_addr            (sfr_addr),
    .sfr_wdata           (sfr_wdata),
    .sfr_wr              (sfr_wr),
    .sfr_rd              (sfr_rd),
    .sfr_rdata           (sfr_rdata),
    .watchdog_enable     (watchdog_enable),
    .cycle_length_select (cycle_length_select),
    .count_run           (count_run),
    .flag_clear          (flag_clear),
    .capture_pin         (capture_pin),
    .capcomp_flag        (capcomp_flag),
    .flag_irq            (flag_irq),
    .module_output_pin   (module_output_pin)
  );

  always #5 clk = ~clk;

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk8(input acm_byte_t got, input acm_byte_t exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // Each access leaves an idle cycle so a strobe never rises again in the step it fell.
  task automatic wr(input acm_byte_t a, input acm_byte_t d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick(1);
    sfr_wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rdchk(input acm_byte_t a, input acm_byte_t exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick(1);
    sfr_rd = 1'b0;
    chk8(sfr_rdata, exp);
    tick(1);
  endtask : rdchk

  task automatic wcnt(input acm_word_t v);
    wr(`ACM_CNT_LO_ADDR, v[7:0]);
    wr(`ACM_CNT_HI_ADDR, v[15:8]);
  endtask : wcnt

  task automatic wcmp(input int m, input acm_word_t v);
    wr(cmp_lo_addr[m], v[7:0]);
    wr(cmp_hi_addr[m], v[15:8]);
  endtask : wcmp

  task automatic run(input int n);
    count_run = 1'b1;
    tick(n);
    count_run = 1'b0;
    tick(2);
  endtask : run

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_count);
  endtask : end_test

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    watchdog_enable = 1'b0;
    cycle_length_select = ACM_LEN_8;
    count_run = 1'b0;
    flag_clear = 3'h0;
    capture_pin = 3'h0;
    err_count = 0;
    samples_checked = 0;
    tick(2);
    reset_n = 1'b1;
    tick(1);
    rdchk(`ACM_CNT_LO_ADDR, `ACM_BYTE_RESET);
    rdchk(`ACM_CNT_HI_ADDR, `ACM_BYTE_RESET);
    rdchk(`ACM_MODE2_ADDR, `ACM_MODE_RESET);
    rdchk(8'h00, 8'h00);
    end_test("reset");
    wcnt(16'h1234);
    rdchk(`ACM_CNT_LO_ADDR, 8'h34);
    rdchk(`ACM_CNT_HI_ADDR, 8'h12);
    wr(`ACM_CNT_HI_ADDR, 8'h56);
    rdchk(`ACM_CNT_HI_ADDR, 8'h12);
    rdchk(`ACM_CNT_LO_ADDR, 8'h34);
    rdchk(`ACM_CNT_HI_ADDR, 8'h56);
    end_test("snapshot");
    wr(`ACM_MODE2_ADDR, 8'h01);
    watchdog_enable = 1'b1;
    wr(`ACM_CNT_LO_ADDR, 8'haa);
    wr(`ACM_CNT_HI_ADDR, 8'hbb);
    wr(`ACM_MODE2_ADDR, 8'hff);
    wr(`ACM_MODE0_ADDR, 8'h11);
    rdchk(`ACM_CNT_LO_ADDR, 8'h34);
    rdchk(`ACM_CNT_HI_ADDR, 8'h56);
    rdchk(`ACM_MODE2_ADDR, 8'h01);
    rdchk(`ACM_MODE0_ADDR, 8'h11);
    chk8({5'h00, capcomp_flag}, 8'h00);
    watchdog_enable = 1'b0;
    wr(`ACM_MODE2_ADDR, 8'h05);
    wr(`ACM_CNT_LO_ADDR, 8'h9a);
    rdchk(`ACM_MODE2_ADDR, 8'h05);
    rdchk(`ACM_CNT_LO_ADDR, 8'h9a);
    end_test("watchdog");
    // The counter sweeps past 0x0010 while the compare value is 0x0110.
    wcmp(0, 16'h0110);
    wr(`ACM_MODE0_ADDR, 8'h49);
    wcnt(16'h0008);
    run(20);
    chk1(capcomp_flag[0], 1'b0);
    wcnt(16'h0108);
    run(20);
    chk1(capcomp_flag[0], 1'b1);
    chk1(flag_irq[0], 1'b1);
    wr(`ACM_MODE0_ADDR, 8'h48);
    tick(1);
    chk1(flag_irq[0], 1'b0);
    flag_clear = 3'h1;
    tick(1);
    flag_clear = 3'h0;
    tick(1);
    chk1(capcomp_flag[0], 1'b0);
    wr(`ACM_MODE0_ADDR, 8'h08);
    wcnt(16'h0108);
    run(20);
    chk1(capcomp_flag[0], 1'b0);
    end_test("match");
    wcmp(1, 16'h0020);
    wr(`ACM_MODE1_ADDR, 8'h44);
    wcnt(16'h0010);
    run(40);
    chk1(module_output_pin[1], 1'b1);
    chk1(capcomp_flag[1], 1'b0);
    // Only the low byte matches here, so plain toggle would leave the pin alone.
    wr(`ACM_MODE1_ADDR, 8'h46);
    wcnt(16'h0310);
    run(40);
    chk1(module_output_pin[1], 1'b0);
    end_test("toggle");
    wcmp(0, 16'h0180);
    for (int s = 0; s < 5; s++) begin
      // Three counts together tell every cycle length apart from its neighbours.
      for (int c = 0; c < 3; c++) begin
        cnt = (c == 0) ? 16'h0200 : (c == 1) ? 16'h0480 : 16'h0800;
        mask = (s == 4) ? 16'hffff : 16'hffff >> (8 - s);
        cycle_length_select = acm_len_t'(s[1:0]);
        wr(`ACM_MODE0_ADDR, (s == 4) ? 8'hc2 : 8'h42);
        wcnt(cnt);
        tick(3);
        chk1(module_output_pin[0], (cnt & mask) >= (16'h0180 & mask));
      end
    end
    end_test("pulse_width");
    wr(`ACM_MODE2_ADDR, 8'h20);
    capture_pin = 3'h4;
    tick(6);
    chk1(capcomp_flag[2], 1'b1);
    flag_clear = 3'h4;
    tick(1);
    flag_clear = 3'h0;
    capture_pin = 3'h0;
    tick(6);
    chk1(capcomp_flag[2], 1'b0);
    wr(`ACM_MODE2_ADDR, 8'h10);
    capture_pin = 3'h4;
    tick(6);
    chk1(capcomp_flag[2], 1'b0);
    capture_pin = 3'h0;
    tick(6);
    chk1(capcomp_flag[2], 1'b1);
    end_test("capture");
    wrap_up();
  end

  // The tests need well under two thousand cycles.
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    wrap_up();
  end

endmodule : tb_top
